/* File: core/amr_pkg.sv */
package amr_pkg;

  // ----------------------------------------------------------------
  // Register index window and per-register indices.
  // ----------------------------------------------------------------
  localparam logic [31:0] AMR_IDX_FIRST = 32'h0000_0800;
  localparam logic [31:0] AMR_IDX_LAST = 32'h0000_0BFF;
  localparam logic [11:0] AMR_IDX_ID = 12'h802;
  localparam logic [11:0] AMR_IDX_PEND_LO = 12'h826;
  localparam logic [11:0] AMR_IDX_PEND_HI = 12'h827;
  localparam logic [11:0] AMR_IDX_ERR = 12'h828;
  localparam logic [11:0] AMR_IDX_CORRECTED_ERROR_INTERRUPT = 12'h82F;
  localparam logic [11:0] AMR_IDX_CMD = 12'h830;
  localparam logic [11:0] AMR_IDX_CMD_RSVD = 12'h831;
  localparam logic [11:0] AMR_IDX_TIMER = 12'h832;
  localparam logic [11:0] AMR_IDX_THERM = 12'h833;
  localparam logic [11:0] AMR_IDX_PERF = 12'h834;
  localparam logic [11:0] AMR_IDX_PIN0 = 12'h835;
  localparam logic [11:0] AMR_IDX_PIN1 = 12'h836;
  localparam logic [11:0] AMR_IDX_ERRV = 12'h837;
  localparam logic [11:0] AMR_IDX_INIT = 12'h838;
  localparam logic [11:0] AMR_IDX_CURR = 12'h839;
  localparam logic [11:0] AMR_IDX_DIV = 12'h83E;
  localparam logic [11:0] AMR_IDX_SELF = 12'h83F;
  // Memory offset bits dropped when forming an index.
  localparam int AMR_MMIO_SHIFT = 4;

  // ----------------------------------------------------------------
  // Transition list check.
  // ----------------------------------------------------------------
  localparam logic [31:0] AMR_LIST_MASK = 32'hFFFF_F800;
  localparam logic [31:0] AMR_LIST_MATCH = 32'h0000_0800;

  // ----------------------------------------------------------------
  // Word store entries, writable masks and reset values.
  // ----------------------------------------------------------------
  localparam int AMR_E_CORRECTED_ERROR_INTERRUPT = 0;
  localparam int AMR_E_TIMER = 1;
  localparam int AMR_E_THERM = 2;
  localparam int AMR_E_PERF = 3;
  localparam int AMR_E_PIN0 = 4;
  localparam int AMR_E_PIN1 = 5;
  localparam int AMR_E_ERRV = 6;
  localparam int AMR_E_INIT = 7;
  localparam int AMR_E_DIV = 8;
  localparam int AMR_E_CMD = 9;
  localparam int AMR_ENTRIES = 10;
  localparam logic [31:0] AMR_WM_VT = 32'h0001_07FF;
  localparam logic [31:0] AMR_WM_TIMER = 32'h0007_00FF;
  localparam logic [31:0] AMR_WM_PIN = 32'h0001_A7FF;
  localparam logic [31:0] AMR_WM_ERRV = 32'h0001_00FF;
  localparam logic [31:0] AMR_WM_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] AMR_WM_DIV = 32'h0000_000B;
  localparam logic [31:0] AMR_WM_CMD = 32'h000C_CFFF;
  localparam logic [31:0] AMR_WM_CMD_HI = 32'hFFFF_FFFF;
  localparam logic [31:0] AMR_WM_SELF = 32'h0000_00FF;
  localparam logic [31:0] AMR_ERR_BITS = 32'h0000_00EF;
  localparam logic [31:0] AMR_RST_VT = 32'h0001_0000;
  localparam logic [31:0] AMR_RST_ZERO = 32'h0000_0000;

  // Mode encoded as {extended_bit, enable}.
  typedef enum logic [1:0] {
    AMR_DISABLED = 2'b00,
    AMR_LEGACY = 2'b01,
    AMR_EXTENDED = 2'b11,
    AMR_INVALID = 2'b10
  } amr_mode_e;

  // Class of register an index lands on.
  typedef enum logic [2:0] {
    AMR_K_NONE,
    AMR_K_MEM,
    AMR_K_CMD_HI,
    AMR_K_ID,
    AMR_K_PEND_LO,
    AMR_K_PEND_HI,
    AMR_K_CURR,
    AMR_K_ERR
  } amr_kind_e;

  // Writable bits of a word store entry.
  function automatic logic [31:0] amr_wmask(input logic [3:0] e);
    case (e)
      4'(AMR_E_TIMER): amr_wmask = AMR_WM_TIMER;
      4'(AMR_E_PIN0), 4'(AMR_E_PIN1): amr_wmask = AMR_WM_PIN;
      4'(AMR_E_ERRV): amr_wmask = AMR_WM_ERRV;
      4'(AMR_E_INIT): amr_wmask = AMR_WM_INIT;
      4'(AMR_E_DIV): amr_wmask = AMR_WM_DIV;
      4'(AMR_E_CMD): amr_wmask = AMR_WM_CMD;
      default: amr_wmask = AMR_WM_VT;
    endcase
  endfunction

  // Vector table entries come out of reset masked.
  function automatic logic [31:0] amr_rst(input logic [3:0] e);
    amr_rst = (e <= 4'(AMR_E_ERRV)) ? AMR_RST_VT : AMR_RST_ZERO;
  endfunction

endpackage

/* File: core/amr_word_store.sv */
`timescale 1ns/100ps
module amr_word_store #(
  parameter int DEPTH = amr_pkg::AMR_ENTRIES
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Write port.
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [31:0] i_wr_data,
  // Registered read port.
  input wire logic [3:0] i_rd_addr,
  output logic [31:0] o_rd_data,
  // Every word, for the logic the words steer.
  output logic [DEPTH*32-1:0] o_words
);
  import amr_pkg::*;

  logic [31:0] mem [DEPTH];

  // Each entry resets to its own value and takes writes at its address.
  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        mem[g] <= amr_rst(4'(g));
      end else if (i_wr_en && i_wr_addr == 4'(g)) begin
        mem[g] <= i_wr_data;
      end
    end
    assign o_words[g*32 +: 32] = mem[g];
  end

  // Read data is registered; an address past the end reads zero.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h0000_0000;
    end else if (32'(i_rd_addr) < DEPTH) begin
      o_rd_data <= mem[i_rd_addr];
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

endmodule // amr_word_store

/* File: core/amr_msr_access.sv */
`timescale 1ns/100ps
module amr_msr_access #(
  parameter int ID_WIDTH = 32
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Register instructions from the core.
  input wire logic i_msr_valid,
  input wire logic i_msr_write,
  input wire logic [31:0] i_msr_index,
  input wire logic [63:0] i_msr_wdata,
  output logic o_msr_done,
  output logic o_msr_fault,
  output logic [63:0] o_msr_rdata,
  // Memory-mapped window.
  input wire logic i_mmio_valid,
  input wire logic i_mmio_write,
  input wire logic [11:0] i_mmio_offset,
  input wire logic [31:0] i_mmio_wdata,
  output logic o_mmio_done,
  output logic [31:0] o_mmio_rdata,
  // Base register writes.
  input wire logic i_base_write,
  input wire logic i_base_enable,
  input wire logic i_base_extended,
  output logic o_base_done,
  output logic o_base_fault,
  output amr_pkg::amr_mode_e o_mode,
  // Hardware state shown through the registers.
  input wire logic [ID_WIDTH-1:0] i_hw_id,
  input wire logic [63:0] i_pending_hi,
  input wire logic [31:0] i_timer_current,
  input wire logic [7:0] i_error_set,
  // Register contents that steer the rest of the controller.
  output logic [31:0] o_timer_vector,
  output logic [31:0] o_timer_initial,
  output logic [31:0] o_timer_divide,
  output logic [63:0] o_command,
  output logic o_command_send,
  output logic o_self_send,
  output logic [7:0] o_self_vector,
  // Transition list checking.
  input wire logic i_list_valid,
  input wire logic i_list_on_exit,
  input wire logic [31:0] i_list_low_dword,
  output logic o_list_done,
  output logic o_list_fail,
  output logic o_list_reload_host,
  output logic o_list_abort
);
  import amr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  amr_mode_e mode;
  logic ext_mode;
  logic legacy_mode;
  logic [ID_WIDTH-1:0] id_reg;
  logic id_loaded;
  logic [31:0] id_word;
  logic [31:0] error_status;
  logic [31:0] cmd_hi;
  logic msr_in_range;
  logic msr_reject;
  logic sel_msr;
  logic sel_valid;
  logic sel_write;
  logic [11:0] sel_idx;
  logic [63:0] sel_wdata;
  logic [11:0] mmio_idx;
  amr_kind_e kind;
  logic [3:0] entry;
  logic ro;
  logic wo;
  logic is_self;
  logic [31:0] wmask;
  logic [31:0] hmask;
  logic bad_bits;
  logic msr_fault;
  logic accept_wr;
  logic mem_wr;
  logic [63:0] live;
  logic [31:0] mem_q;
  logic [AMR_ENTRIES*32-1:0] words;
  logic s1_msr_valid;
  logic s1_mmio_valid;
  logic s1_fault;
  logic s1_mem;
  logic s1_mmio_live;
  logic [63:0] s1_live;

  assign ext_mode = (mode == AMR_EXTENDED);
  assign legacy_mode = (mode == AMR_LEGACY);
  assign o_mode = mode;

  // ----------------------------------------------------------------
  // Operating mode.
  // ----------------------------------------------------------------

  // Base writes set the mode; a write naming the invalid pair faults.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode <= AMR_LEGACY;
      o_base_done <= 1'b0;
      o_base_fault <= 1'b0;
    end else begin
      o_base_done <= i_base_write;
      o_base_fault <= i_base_write && i_base_extended && !i_base_enable;
      if (i_base_write && !(i_base_extended && !i_base_enable)) begin
        mode <= amr_mode_e'({i_base_extended, i_base_enable});
      end
    end
  end

  // ----------------------------------------------------------------
  // Identifier.
  // ----------------------------------------------------------------

  // The hardware identifier is caught once, on the first edge after reset.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      id_reg <= '0;
      id_loaded <= 1'b0;
    end else if (!id_loaded) begin
      id_reg <= i_hw_id;
      id_loaded <= 1'b1;
    end
  end

  // Bits above the implemented width read as zero.
  assign id_word = 32'(id_reg);

  // ----------------------------------------------------------------
  // Request selection.
  // ----------------------------------------------------------------

  // Only one interface reaches the registers in each enabled mode; none does when disabled.
  assign msr_in_range = (i_msr_index >= AMR_IDX_FIRST) && (i_msr_index <= AMR_IDX_LAST);
  assign msr_reject = i_msr_valid && !(ext_mode && msr_in_range);
  assign mmio_idx = AMR_IDX_FIRST[11:0] + {4'h0, i_mmio_offset[11:AMR_MMIO_SHIFT]};
  assign sel_msr = ext_mode;
  assign sel_valid = ext_mode ? (i_msr_valid && msr_in_range) : (i_mmio_valid && legacy_mode);
  assign sel_write = ext_mode ? i_msr_write : i_mmio_write;
  assign sel_idx = ext_mode ? i_msr_index[11:0] : mmio_idx;
  assign sel_wdata = ext_mode ? i_msr_wdata : {32'h0000_0000, i_mmio_wdata};

  // ----------------------------------------------------------------
  // Index decode.
  // ----------------------------------------------------------------

  // Classifies the index and gives its access type and store entry.
  always_comb begin
    kind = AMR_K_NONE;
    entry = 4'h0;
    ro = 1'b0;
    wo = 1'b0;
    is_self = 1'b0;
    case (sel_idx)
      AMR_IDX_ID: begin
        kind = sel_msr ? AMR_K_ID : AMR_K_NONE;
        ro = 1'b1;
      end
      AMR_IDX_PEND_LO: begin
        kind = AMR_K_PEND_LO;
        ro = 1'b1;
      end
      AMR_IDX_PEND_HI: begin
        kind = AMR_K_PEND_HI;
        ro = 1'b1;
      end
      AMR_IDX_CURR: begin
        kind = AMR_K_CURR;
        ro = 1'b1;
      end
      AMR_IDX_ERR: kind = AMR_K_ERR;
      AMR_IDX_CORRECTED_ERROR_INTERRUPT: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_CORRECTED_ERROR_INTERRUPT);
      end
      AMR_IDX_CMD: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_CMD);
      end
      AMR_IDX_CMD_RSVD: kind = sel_msr ? AMR_K_NONE : AMR_K_CMD_HI;
      AMR_IDX_TIMER: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_TIMER);
      end
      AMR_IDX_THERM: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_THERM);
      end
      AMR_IDX_PERF: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_PERF);
      end
      AMR_IDX_PIN0: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_PIN0);
      end
      AMR_IDX_PIN1: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_PIN1);
      end
      AMR_IDX_ERRV: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_ERRV);
      end
      AMR_IDX_INIT: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_INIT);
      end
      AMR_IDX_DIV: begin
        kind = AMR_K_MEM;
        entry = 4'(AMR_E_DIV);
      end
      AMR_IDX_SELF: begin
        is_self = sel_msr;
        wo = 1'b1;
      end
      default: kind = AMR_K_NONE;
    endcase
  end

  // Writable bits; the error register takes only zero over the core path.
  always_comb begin
    wmask = 32'h0000_0000;
    hmask = 32'h0000_0000;
    if (kind == AMR_K_MEM) begin
      wmask = amr_wmask(entry);
    end else if (kind == AMR_K_CMD_HI) begin
      wmask = AMR_WM_CMD_HI;
    end else if (is_self) begin
      wmask = AMR_WM_SELF;
    end else if (kind == AMR_K_ERR && !sel_msr) begin
      wmask = AMR_ERR_BITS;
    end
    if (kind == AMR_K_MEM && entry == 4'(AMR_E_CMD)) begin
      hmask = AMR_WM_CMD_HI;
    end
  end

  // ----------------------------------------------------------------
  // Access checks, made before anything is updated.
  // ----------------------------------------------------------------
  assign bad_bits = |(sel_wdata & ~{hmask, wmask});
  assign msr_fault = msr_reject || (sel_msr && sel_valid && (
    (kind == AMR_K_NONE && !is_self) ||
    (sel_write && ro) ||
    (!sel_write && wo) ||
    (sel_write && bad_bits)));
  assign accept_wr = sel_valid && sel_write && !(sel_msr && msr_fault);
  assign mem_wr = accept_wr && kind == AMR_K_MEM;

  // ----------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------

  // Writes land on the edge that takes them, so a later read sees them.
  amr_word_store #(
    .DEPTH(AMR_ENTRIES)
  ) u_store (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(mem_wr),
    .i_wr_addr(entry),
    .i_wr_data(sel_wdata[31:0] & wmask),
    .i_rd_addr(entry),
    .o_rd_data(mem_q),
    .o_words(words)
  );

  // Upper command word, written by a 64-bit core write or offset 310H.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cmd_hi <= 32'h0000_0000;
    end else if (mem_wr && entry == 4'(AMR_E_CMD) && sel_msr) begin
      cmd_hi <= sel_wdata[63:32];
    end else if (accept_wr && kind == AMR_K_CMD_HI) begin
      cmd_hi <= sel_wdata[31:0];
    end
  end

  // Error bits are set by hardware and cleared by an accepted write.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      error_status <= 32'h0000_0000;
    end else begin
      error_status <= ((accept_wr && kind == AMR_K_ERR) ? 32'h0000_0000 : error_status)
        | ({24'h00_0000, i_error_set} & AMR_ERR_BITS);
    end
  end

  // Command and self-interrupt requests go out as one-cycle pulses.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_command_send <= 1'b0;
      o_self_send <= 1'b0;
      o_self_vector <= 8'h00;
    end else begin
      o_command_send <= mem_wr && entry == 4'(AMR_E_CMD);
      o_self_send <= accept_wr && is_self;
      if (accept_wr && is_self) begin
        o_self_vector <= sel_wdata[7:0];
      end
    end
  end

  assign o_timer_vector = words[AMR_E_TIMER*32 +: 32];
  assign o_timer_initial = words[AMR_E_INIT*32 +: 32];
  assign o_timer_divide = words[AMR_E_DIV*32 +: 32];
  assign o_command = {cmd_hi, words[AMR_E_CMD*32 +: 32]};

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------

  // Non-stored values are sampled in the cycle the request is taken.
  always_comb begin
    live = 64'h0000_0000_0000_0000;
    case (kind)
      AMR_K_ID: live[31:0] = id_word;
      AMR_K_PEND_LO: live[31:0] = i_pending_hi[31:0];
      AMR_K_PEND_HI: live[31:0] = i_pending_hi[63:32];
      AMR_K_CURR: live[31:0] = i_timer_current;
      AMR_K_ERR: live[31:0] = error_status;
      AMR_K_CMD_HI: live[31:0] = cmd_hi;
      AMR_K_MEM: live[63:32] = (sel_msr && entry == 4'(AMR_E_CMD)) ? cmd_hi : 32'h0000_0000;
      default: live = 64'h0000_0000_0000_0000;
    endcase
  end

  // First stage: holds the request while the store reads out.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s1_msr_valid <= 1'b0;
      s1_mmio_valid <= 1'b0;
      s1_fault <= 1'b0;
      s1_mem <= 1'b0;
      s1_mmio_live <= 1'b0;
      s1_live <= 64'h0000_0000_0000_0000;
    end else begin
      s1_msr_valid <= i_msr_valid;
      s1_mmio_valid <= i_mmio_valid;
      s1_fault <= msr_fault;
      s1_mem <= kind == AMR_K_MEM && !sel_write;
      s1_mmio_live <= !sel_msr && legacy_mode && !i_mmio_write;
      s1_live <= sel_write ? 64'h0000_0000_0000_0000 : live;
    end
  end

  // Second stage: answers in order, one per cycle, with no stall.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_msr_done <= 1'b0;
      o_msr_fault <= 1'b0;
      o_msr_rdata <= 64'h0000_0000_0000_0000;
      o_mmio_done <= 1'b0;
      o_mmio_rdata <= 32'h0000_0000;
    end else begin
      o_msr_done <= s1_msr_valid;
      o_msr_fault <= s1_msr_valid && s1_fault;
      o_msr_rdata <= (s1_msr_valid && !s1_fault) ?
        {s1_live[63:32], s1_mem ? mem_q : s1_live[31:0]} : 64'h0000_0000_0000_0000;
      o_mmio_done <= s1_mmio_valid;
      o_mmio_rdata <= (s1_mmio_valid && s1_mmio_live) ?
        (s1_mem ? mem_q : s1_live[31:0]) : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Transition list entry check.
  // ----------------------------------------------------------------

  // A matching entry fails; entry reloads host state, exit aborts.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_list_done <= 1'b0;
      o_list_fail <= 1'b0;
      o_list_reload_host <= 1'b0;
      o_list_abort <= 1'b0;
    end else begin
      o_list_done <= i_list_valid;
      o_list_fail <= i_list_valid && (i_list_low_dword & AMR_LIST_MASK) == AMR_LIST_MATCH;
      o_list_reload_host <= i_list_valid && !i_list_on_exit &&
        (i_list_low_dword & AMR_LIST_MASK) == AMR_LIST_MATCH;
      o_list_abort <= i_list_valid && i_list_on_exit &&
        (i_list_low_dword & AMR_LIST_MASK) == AMR_LIST_MATCH;
    end
  end

endmodule // amr_msr_access

/* File: verif/amr_msr_access_asserts.sv */
`timescale 1ns/100ps
module amr_msr_access_asserts (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Core register path.
  input wire logic i_msr_valid,
  input wire logic i_msr_write,
  input wire logic [31:0] i_msr_index,
  input wire logic [63:0] i_msr_wdata,
  input wire logic o_msr_done,
  input wire logic o_msr_fault,
  input wire logic [63:0] o_msr_rdata,
  // Base register and mode.
  input wire logic i_base_write,
  input wire logic i_base_enable,
  input wire logic i_base_extended,
  input wire logic o_base_fault,
  input wire amr_pkg::amr_mode_e o_mode,
  // Transition list checking.
  input wire logic i_list_valid,
  input wire logic i_list_on_exit,
  input wire logic [31:0] i_list_low_dword,
  input wire logic o_list_fail,
  input wire logic o_list_abort
);
  import amr_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic wr;
  // A core write request in the current cycle.
  assign wr = i_msr_valid && i_msr_write;
  AST_DONE_LAT: assert property (i_msr_valid |-> ##2 o_msr_done)
    else $error("core answer not two cycles after request");
  AST_NOT_EXT: assert property (i_msr_valid && o_mode != AMR_EXTENDED |-> ##2 o_msr_fault)
    else $error("core access outside extended mode did not fault");
  AST_RSVD: assert property (i_msr_valid && i_msr_index == 32'h0000_0831 |-> ##2 o_msr_fault)
    else $error("reserved index did not fault");
  AST_RO_WR: assert property (wr && i_msr_index inside {32'h0000_0802, 32'h0000_0826,
    32'h0000_0827, 32'h0000_0839} |-> ##2 o_msr_fault) else $error("read-only write accepted");
  AST_WO_RD: assert property (i_msr_valid && !i_msr_write && i_msr_index == 32'h0000_083F
    |-> ##2 o_msr_fault && o_msr_rdata == 64'h0) else $error("write-only read returned data");
  AST_UPPER: assert property (wr && i_msr_index != 32'h0000_0830 &&
    i_msr_wdata[63:32] != 32'h0 |-> ##2 o_msr_fault) else $error("upper half write accepted");
  AST_ERR_NZ: assert property (wr && i_msr_index == 32'h0000_0828 &&
    i_msr_wdata != 64'h0 |-> ##2 o_msr_fault) else $error("non-zero error status write accepted");
  AST_BASE_INV: assert property (i_base_write && i_base_extended && !i_base_enable
    |=> o_base_fault && $stable(o_mode)) else $error("invalid mode entered");
  AST_LIST: assert property (i_list_valid |=>
    o_list_fail == (($past(i_list_low_dword) & AMR_LIST_MASK) == AMR_LIST_MATCH))
    else $error("list entry verdict wrong");
  AST_ABORT: assert property (i_list_valid |=>
    o_list_abort == (o_list_fail && $past(i_list_on_exit))) else $error("list abort wrong");
  // Main scenarios reached.
  cover property (i_msr_valid ##1 i_msr_valid);
  cover property (o_list_abort);
  cover property (o_base_fault);
endmodule // amr_msr_access_asserts

bind amr_msr_access amr_msr_access_asserts u_chk (.*);

/* File: verif/amr_core_model.sv */
`timescale 1ns/100ps
module amr_core_model (
  // Clock.
  input wire logic i_clock,
  // Register instruction towards the block.
  output logic o_valid,
  output logic o_write,
  output logic [31:0] o_index,
  output logic [63:0] o_wdata
);
  // Requests leave one per cycle in program order, never waiting for fences.
  task automatic put(input logic w, input logic [31:0] idx, input logic [63:0] d);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_write = w;
    o_index = idx;
    o_wdata = d;
  endtask
  // Released lines show the inverse of the last value so nothing stale passes.
  task automatic idle();
    @(negedge i_clock);
    o_valid = 1'b0;
    o_write = ~o_write;
    o_index = ~o_index;
    o_wdata = ~o_wdata;
  endtask
  // Idle at time zero.
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_index = 32'h0;
    o_wdata = 64'h0;
  end
endmodule // amr_core_model

/* File: verif/amr_msr_access_tb.sv */
`timescale 1ns/100ps
module amr_msr_access_tb;
  import amr_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_msr_valid, i_msr_write, o_msr_done, o_msr_fault, i_mmio_valid, i_mmio_write;
  logic o_mmio_done, i_base_write, i_base_enable, i_base_extended, o_base_done, o_base_fault;
  logic o_command_send, o_self_send, i_list_valid, i_list_on_exit, o_list_done, o_list_fail;
  logic o_list_reload_host, o_list_abort;
  logic [11:0] i_mmio_offset;
  logic [7:0] i_error_set, o_self_vector;
  logic [31:0] i_msr_index, i_mmio_wdata, o_mmio_rdata, i_timer_current, o_timer_vector;
  logic [31:0] o_timer_initial, o_timer_divide, i_list_low_dword, i_hw_id, d;
  logic [63:0] i_msr_wdata, o_msr_rdata, i_pending_hi, o_command;
  amr_mode_e o_mode;
  logic [64:0] exp_q[$];
  logic [31:0] mq[$];
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 32'h610d27aa;
  amr_msr_access u_dut (.*);
  amr_core_model u_core (.i_clock(i_clock), .o_valid(i_msr_valid), .o_write(i_msr_write),
    .o_index(i_msr_index), .o_wdata(i_msr_wdata));
  // Clock at 50 MHz.
  always #10 i_clock = ~i_clock;
  // Compares one result and counts it.
  task automatic check(input string name, input logic [64:0] e, input logic [64:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Notes the expected answer, then issues one core request.
  task automatic msr(input logic w, input logic [31:0] i, input logic [63:0] v,
    input logic f, input logic [63:0] r);
    exp_q.push_back({f, r});
    u_core.put(w, i, v);
    u_core.idle();
  endtask
  // Notes the expected data, then issues one window request.
  task automatic mmio(input logic w, input logic [11:0] off, input logic [31:0] v, e);
    mq.push_back(e);
    @(negedge i_clock);
    i_mmio_valid = 1'b1;
    i_mmio_write = w;
    i_mmio_offset = off;
    i_mmio_wdata = v;
    @(negedge i_clock);
    i_mmio_valid = 1'b0;
  endtask
  // Writes the base register and checks fault and mode one cycle later.
  task automatic base(input logic en, input logic ex, input logic f, input logic [1:0] m);
    @(negedge i_clock);
    i_base_write = 1'b1;
    i_base_enable = en;
    i_base_extended = ex;
    @(negedge i_clock);
    i_base_write = 1'b0;
    check("base", 65'({1'b1, f, m}), 65'({o_base_done, o_base_fault, o_mode}));
  endtask
  // Takes the oldest note off each queue whenever an answer appears.
  always @(negedge i_clock) begin
    if (o_msr_done === 1'b1)
      check("core", exp_q.size() ? exp_q.pop_front() : 'x, {o_msr_fault, o_msr_rdata});
    if (o_mmio_done === 1'b1)
      check("window", mq.size() ? 65'(mq.pop_front()) : 'x, 65'(o_mmio_rdata));
  end
  // Cuts a hang short.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end
  // Main sequence.
  initial begin
    {i_mmio_valid, i_mmio_write, i_base_write, i_base_enable, i_base_extended} = 5'h0;
    {i_list_valid, i_list_on_exit, i_mmio_offset, i_mmio_wdata, i_list_low_dword} = '0;
    i_error_set = 8'h0;
    i_hw_id = 32'h0000_1234;
    i_pending_hi = {$random(seed), $random(seed)};
    i_timer_current = $random(seed);
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    check("mode", 65'(2'b01), 65'(o_mode));
    msr(1'b0, 32'h832, 64'h0, 1'b1, 64'h0);
    msr(1'b1, 32'h83F, 64'h41, 1'b1, 64'h0);
    check("self", 65'(0), 65'({o_self_send, o_self_vector}));
    d = $random(seed);
    mmio(1'b1, 12'h320, d, 32'h0);
    mmio(1'b0, 12'h320, 32'h0, d & AMR_WM_TIMER);
    mmio(1'b1, 12'h310, ~d, 32'h0);
    mmio(1'b0, 12'h310, 32'h0, ~d);
    $display("test legacy done");
    base(1'b0, 1'b1, 1'b1, 2'b01);
    base(1'b1, 1'b1, 1'b0, 2'b11);
    mmio(1'b0, 12'h320, 32'h0, 32'h0);
    $display("test mode done");
    msr(1'b0, 32'h802, 64'h0, 1'b0, {32'h0, i_hw_id});
    msr(1'b1, 32'h802, 64'h5, 1'b1, 64'h0);
    msr(1'b0, 32'h83F, 64'h0, 1'b1, 64'h0);
    msr(1'b0, 32'h831, 64'h0, 1'b1, 64'h0);
    msr(1'b1, 32'h831, 64'h0, 1'b1, 64'h0);
    msr(1'b0, 32'h826, 64'h0, 1'b0, {32'h0, i_pending_hi[31:0]});
    msr(1'b0, 32'h827, 64'h0, 1'b0, {32'h0, i_pending_hi[63:32]});
    msr(1'b0, 32'h839, 64'h0, 1'b0, {32'h0, i_timer_current});
    $display("test access done");
    exp_q.push_back({1'b0, 64'h0});
    exp_q.push_back({1'b0, 32'h0, ~d & AMR_WM_TIMER});
    u_core.put(1'b1, 32'h832, {32'h0, ~d & AMR_WM_TIMER});
    u_core.put(1'b0, 32'h832, 64'h0);
    u_core.idle();
    msr(1'b1, 32'h832, {32'h1, d & AMR_WM_TIMER}, 1'b1, 64'h0);
    msr(1'b1, 32'h832, {32'h0, d | ~AMR_WM_TIMER}, 1'b1, 64'h0);
    mmio(1'b1, 12'h320, d, 32'h0);
    msr(1'b0, 32'h832, 64'h0, 1'b0, {32'h0, ~d & AMR_WM_TIMER});
    msr(1'b1, 32'h830, {~d, d & AMR_WM_CMD}, 1'b0, 64'h0);
    check("command", 65'({1'b1, ~d, d & AMR_WM_CMD}), 65'({o_command_send, o_command}));
    msr(1'b0, 32'h830, 64'h0, 1'b0, {~d, d & AMR_WM_CMD});
    i_error_set = 8'hFF;
    @(negedge i_clock);
    i_error_set = 8'h00;
    msr(1'b0, 32'h828, 64'h0, 1'b0, {32'h0, AMR_ERR_BITS});
    msr(1'b1, 32'h828, 64'h4, 1'b1, 64'h0);
    msr(1'b1, 32'h828, 64'h0, 1'b0, 64'h0);
    msr(1'b0, 32'h828, 64'h0, 1'b0, 64'h0);
    msr(1'b1, 32'h83F, 64'h41, 1'b0, 64'h0);
    check("self", 65'({1'b1, 8'h41}), 65'({o_self_send, o_self_vector}));
    msr(1'b1, 32'h838, {32'h0, d}, 1'b0, 64'h0);
    msr(1'b1, 32'h83E, {32'h0, d & AMR_WM_DIV}, 1'b0, 64'h0);
    check("timer", 65'({~d & AMR_WM_TIMER, d}), 65'({o_timer_vector, o_timer_initial}));
    check("divide", 65'(d & AMR_WM_DIV), 65'(o_timer_divide));
    $display("test write done");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      if (!i[0])
        d[31:11] = 21'h1;
      else
        d[11] = 1'b0;
      @(negedge i_clock);
      i_list_valid = 1'b1;
      i_list_on_exit = i[1];
      i_list_low_dword = d;
      @(negedge i_clock);
      i_list_valid = 1'b0;
      check("list", 65'({1'b1, !i[0], !i[0] && !i[1], !i[0] && i[1]}),
        65'({o_list_done, o_list_fail, o_list_reload_host, o_list_abort}));
    end
    $display("test list done");
    base(1'b0, 1'b0, 1'b0, 2'b00);
    msr(1'b0, 32'h832, 64'h0, 1'b1, 64'h0);
    repeat (4) @(negedge i_clock);
    check("queue", 65'(0), 65'(exp_q.size() + mq.size()));
    summarize();
  end
endmodule // amr_msr_access_tb
